// ==== common/rmd_pkg.sv ====
// Constants for the RF main divider word decoder
`default_nettype none
package rmd_pkg;
    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int          WORD_W      = 24;
    localparam logic [4:0]  WORD_BITS   = 5'h18;   // Bits in one programming word
    localparam int          SEL_POS     = 0;       // Word select bit position
    localparam logic        SEL_MAIN    = 1'b0;    // Select value of the main divider word
    localparam int          FN_LSB      = 1;
    localparam int          FN_W        = 12;
    localparam int          N_LSB       = 13;
    localparam int          N_W         = 11;
    localparam int          C_LSB       = 4;
    localparam int          C_W         = 7;
    localparam int          B_LSB       = 2;
    localparam int          B_W         = 2;
    localparam int          A_LSB       = 0;
    localparam int          A_W         = 2;
    localparam int          RATIO_W     = 12;

    // ------------------------------------------------------------
    // Prescaler and divide range
    // ------------------------------------------------------------
    localparam int          BASE_LOW    = 8;       // 8/9/12/13 prescaler
    localparam int          BASE_HIGH   = 16;      // 16/17/20/21 prescaler
    localparam int          B_WEIGHT    = 4;
    localparam logic [11:0] N_MIN_LOW   = 12'h019; // 25
    localparam logic [11:0] N_ORD2_MAX  = 12'h01a; // 26
    localparam logic [11:0] N_ORD3_MAX  = 12'h01e; // 30
    localparam logic [11:0] N_MAX_LOW   = 12'h3ff; // 1023

    // ------------------------------------------------------------
    // Quick-start programming state
    // ------------------------------------------------------------
    localparam logic [2:0]  ORDER_2     = 3'h2;
    localparam logic [2:0]  ORDER_3     = 3'h3;
    localparam logic [2:0]  ORDER_RST   = 3'h3;    // Third order modulator
    localparam logic        FRAC22_RST  = 1'b0;    // 12-bit fractional modulus
    localparam logic        DITHER_RST  = 1'b0;
    localparam logic        FASTLK_RST  = 1'b0;
endpackage
`default_nettype wire

// ==== verilog/rmd_sync.sv ====
// Two flip-flop synchroniser for a group of pin inputs
`default_nettype none
module rmd_sync #(
    parameter int W = 3
) (
    input  wire logic         core_clk, // Core clock
    input  wire logic         rst_n,    // Asynchronous reset, active low
    input  wire logic [W-1:0] async_in, // Pins from outside the clock domain
    output logic      [W-1:0] sync_out  // Synchronised levels
);
    logic [W-1:0] meta_r;

    // ------------------------------------------------------------
    // Two stages; only the second stage reads the first
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/rmd_main_divider.sv ====
// RF main divider word receiver and decoder
// ------------------------------------------------------------
// ------------------------------------------------------------
`default_nettype none
module rmd_main_divider
    import rmd_pkg::*;
(
    input  wire logic                core_clk,              // Core clock, 200 MHz
    input  wire logic                rst_n,                 // Asynchronous reset, active low
    input  wire logic                ser_clk,               // Serial clock pin
    input  wire logic                ser_data,              // Serial data pin
    input  wire logic                ser_le,                // Serial latch enable pin
    input  wire logic                rf_prescaler_select,   // 0: 8/9/12/13, 1: 16/17/20/21
    output logic [N_W-1:0]           rf_integer_divide,     // Applied integer field
    output logic [FN_W-1:0]          rf_fraction_numerator, // Applied fractional numerator
    output logic [C_W-1:0]           rf_coarse_count,       // Coarse count
    output logic [B_W-1:0]           rf_b_count,            // B count
    output logic [A_W-1:0]           rf_a_count,            // A count
    output logic [RATIO_W-1:0]       rf_divide_ratio,       // Effective divide ratio
    output logic                     word_loaded,           // Pulse: new word applied
    output logic                     range_fault,           // Ratio illegal for order
    output logic [2:0]               modulator_order,       // Modulator order
    output logic                     frac_modulus_22bit,    // 0: 12-bit modulus
    output logic                     dither_enable,         // Dithering on
    output logic                     fastlock_enable        // Fast-lock on
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0]        pins_s;
    logic              sclk_s;
    logic              sdat_s;
    logic              sle_s;
    logic              sclk_prev_r;
    logic              sle_prev_r;
    logic              sclk_rise;
    logic              sle_rise;
    logic [WORD_W-1:0] shift_r;
    logic [4:0]        bit_cnt_r;
    logic              load;
    logic              psel_r;
    logic [RATIO_W-1:0] ratio_nxt;
    logic              fault_nxt;

    // Pin synchroniser
    rmd_sync #(
        .W        (3)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({ser_clk, ser_data, ser_le}),
        .sync_out (pins_s)
    );

    assign sclk_s = pins_s[2];
    assign sdat_s = pins_s[1];
    assign sle_s  = pins_s[0];

    // ------------------------------------------------------------
    // Serial edge detection
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_r <= 1'b0;
            sle_prev_r  <= 1'b0;
        end else begin
            sclk_prev_r <= sclk_s;
            sle_prev_r  <= sle_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_r;
    assign sle_rise  = sle_s & ~sle_prev_r;

    // Shift register, MSB first, select bit arrives last
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= '0;
        end else if (sclk_rise) begin
            shift_r <= {shift_r[WORD_W-2:0], sdat_s};
        end
    end

    // Bit counter, saturating, restarted by each latch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= 5'h00;
        end else if (sle_rise) begin
            bit_cnt_r <= 5'h00;
        end else if (sclk_rise && bit_cnt_r != WORD_BITS) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // Latch only a full word whose select bit marks the main divider
    assign load = sle_rise && (bit_cnt_r == WORD_BITS)
                  && (shift_r[SEL_POS] == SEL_MAIN);

    // ------------------------------------------------------------
    // Applied word fields
    // ------------------------------------------------------------
    // All fields change in one cycle, never partly
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rf_integer_divide     <= '0;
            rf_fraction_numerator <= '0;
            rf_coarse_count       <= '0;
            rf_b_count            <= '0;
            rf_a_count            <= '0;
        end else if (load) begin
            rf_integer_divide     <= shift_r[N_LSB +: N_W];
            rf_fraction_numerator <= shift_r[FN_LSB +: FN_W];
            rf_coarse_count       <= shift_r[N_LSB+C_LSB +: C_W];
            rf_b_count            <= shift_r[N_LSB+B_LSB +: B_W];
            rf_a_count            <= shift_r[N_LSB+A_LSB +: A_W];
        end
    end

    // Load pulse and registered prescaler select
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_loaded <= 1'b0;
            psel_r      <= 1'b0;
        end else begin
            word_loaded <= load;
            psel_r      <= rf_prescaler_select;
        end
    end

    // ------------------------------------------------------------
    // Effective ratio and legal range
    // ------------------------------------------------------------
    // Ratio = base * coarse + 4 * B + A, with only bit 0 of B used at the low base
    always_comb begin
        logic [RATIO_W-1:0] base_part;
        logic [1:0]         b_eff;
        base_part = '0;
        b_eff     = 2'h0;
        if (psel_r) begin
            base_part = {1'b0, rf_coarse_count, 4'h0};
            b_eff     = rf_b_count;
        end else begin
            base_part = {2'b00, rf_coarse_count, 3'h0};
            b_eff     = {1'b0, rf_b_count[0]};
        end
        ratio_nxt = base_part + {8'h00, b_eff, 2'h0} + {10'h000, rf_a_count};
    end

    // Flag ratios that the low prescaler cannot use at this order
    always_comb begin
        fault_nxt = 1'b0;
        if (!psel_r) begin
            if (ratio_nxt < N_MIN_LOW || ratio_nxt > N_MAX_LOW) begin
                fault_nxt = 1'b1;
            end else if (ratio_nxt <= N_ORD2_MAX) begin
                fault_nxt = (modulator_order != ORDER_2);
            end else if (ratio_nxt <= N_ORD3_MAX) begin
                fault_nxt = (modulator_order != ORDER_2)
                            && (modulator_order != ORDER_3);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rf_divide_ratio <= '0;
            range_fault     <= 1'b0;
        end else begin
            rf_divide_ratio <= ratio_nxt;
            range_fault     <= fault_nxt;
        end
    end

    // ------------------------------------------------------------
    // Quick-start modulator configuration
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modulator_order    <= ORDER_RST;
            frac_modulus_22bit <= FRAC22_RST;
            dither_enable      <= DITHER_RST;
            fastlock_enable    <= FASTLK_RST;
        end else begin
            modulator_order    <= ORDER_RST;
            frac_modulus_22bit <= FRAC22_RST;
            dither_enable      <= DITHER_RST;
            fastlock_enable    <= FASTLK_RST;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_SELECT_ZERO: assert property (
        word_loaded |-> ($past(shift_r[SEL_POS]) == SEL_MAIN) && ($past(bit_cnt_r) == WORD_BITS)
    ) else $error("word applied without select bit zero");

    AST_FIELDS_SPLIT: assert property (
        load |=> (rf_integer_divide == $past(shift_r[23:13]))
                 && (rf_fraction_numerator == $past(shift_r[12:1]))
    ) else $error("integer or fraction field taken from wrong bits");

    AST_COUNTS_SLICE: assert property (
        {rf_coarse_count, rf_b_count, rf_a_count} == rf_integer_divide
    ) else $error("counts do not match integer field");

    AST_HOLD_UNTIL_LOAD: assert property (
        !load |=> $stable(rf_integer_divide) && $stable(rf_fraction_numerator)
    ) else $error("divide setting changed without a full word");

    // Without a load the counts seen next cycle are the ones the ratio was built from
    AST_BASE_LOW: assert property (
        (!psel_r && !load && !rf_b_count[1])
        |=> int'(rf_divide_ratio) == 8 * int'(rf_coarse_count)
            + 4 * int'(rf_b_count) + int'(rf_a_count)
    ) else $error("low prescaler ratio wrong");

    AST_B_UPPER_IGNORED: assert property (
        (!psel_r && !load && rf_b_count[1])
        |=> int'(rf_divide_ratio) == 8 * int'(rf_coarse_count)
            + 4 * int'(rf_b_count[0]) + int'(rf_a_count)
    ) else $error("upper B bit affected low prescaler ratio");

    AST_BASE_HIGH: assert property (
        (psel_r && !load)
        |=> int'(rf_divide_ratio) == 16 * int'(rf_coarse_count)
            + 4 * int'(rf_b_count) + int'(rf_a_count)
    ) else $error("high prescaler ratio wrong");

    AST_RANGE_LIMITS: assert property (
        (!psel_r && (ratio_nxt < 12'd25 || ratio_nxt > 12'd1023)) |=> range_fault
    ) else $error("out of range ratio not flagged");

    AST_ORDER3_WINDOW: assert property (
        (!psel_r && modulator_order == 3'd3 && ratio_nxt >= 12'd25 && ratio_nxt <= 12'd26)
        |=> range_fault ##1 (range_fault || !$stable(rf_divide_ratio))
    ) else $error("divide 25-26 at third order not flagged");

    AST_QUICK_START: assert property (
        modulator_order == 3'd3 && !frac_modulus_22bit && !dither_enable && !fastlock_enable
    ) else $error("quick start configuration lost");
endmodule
`default_nettype wire

// ==== dv/rmd_host_model.sv ====
// Host controller model that shifts programming words into the decoder
`default_nettype none
module rmd_host_model (
    input  wire logic core_clk, // Core clock, paces the serial timing
    output logic      ser_clk,  // Serial clock, still outside frames
    output logic      ser_data, // Serial data, MSB first
    output logic      ser_le    // Latch enable, rises to end a word
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels before the first frame
    initial begin
        ser_clk  = 1'b0;
        ser_data = 1'b0;
        ser_le   = 1'b0;
    end

    // Half of the 160 ns serial period is 16 core cycles
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Shift nbits of a word, select bit last, then pulse latch enable
    task automatic send_bits(input logic [31:0] bits, input int nbits);
        for (int i = nbits - 1; i >= 0; i--) begin
            ser_data = bits[i];
            wait_cyc(16);
            ser_clk = 1'b1;
            wait_cyc(16);
            ser_clk = 1'b0;
        end
        wait_cyc(8);
        ser_le = 1'b1;
        ser_data = ~ser_data; // Data inverted with latch enable: no stale level left behind
        wait_cyc(16);
        ser_le = 1'b0;
        wait_cyc(8);
    endtask
endmodule
`default_nettype wire

// ==== dv/rmd_main_divider_tb_top.sv ====
// Self-checking testbench for the RF main divider word decoder
`default_nettype none
module rmd_main_divider_tb_top import rmd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk = 1'b0;
    logic              rst_n;
    logic              rf_prescaler_select;
    wire logic         ser_clk;
    wire logic         ser_data;
    wire logic         ser_le;
    logic [N_W-1:0]    rf_integer_divide;
    logic [FN_W-1:0]   rf_fraction_numerator;
    logic [C_W-1:0]    rf_coarse_count;
    logic [B_W-1:0]    rf_b_count;
    logic [A_W-1:0]    rf_a_count;
    logic [RATIO_W-1:0] rf_divide_ratio;
    logic              word_loaded;
    logic              range_fault;
    logic [2:0]        modulator_order;
    logic              frac_modulus_22bit;
    logic              dither_enable;
    logic              fastlock_enable;
    int                fail_count = 0;
    int                num_checks = 0;
    int                loads = 0;
    int                exp_loads = 0;
    logic [10:0]       exp_n = '0;
    logic [10:0]       lat_n = '0;
    logic [11:0]       exp_fn = '0;
    logic [11:0]       lat_f = '0;
    // Low prescaler table; coarse >= max(A,B) kept
    // Ratios 24..27, 30, 31 and 1023 so the range flag is exercised
    logic [10:0]       n_tab [7] = '{11'h030, 11'h031, 11'h032, 11'h033, 11'h036,
                                     11'h03f, 11'h7f7};
    logic [11:0]       f_tab [7] = '{12'hfff, 12'h001, 12'h800, 12'h5a5, 12'ha5a,
                                     12'h000, 12'h123};

    always #2.5 core_clk = ~core_clk;

    rmd_main_divider u_rmd_main_divider (
        .core_clk(core_clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_le(ser_le), .rf_prescaler_select(rf_prescaler_select),
        .rf_integer_divide(rf_integer_divide), .rf_fraction_numerator(rf_fraction_numerator),
        .rf_coarse_count(rf_coarse_count), .rf_b_count(rf_b_count),
        .rf_a_count(rf_a_count), .rf_divide_ratio(rf_divide_ratio),
        .word_loaded(word_loaded), .range_fault(range_fault),
        .modulator_order(modulator_order), .frac_modulus_22bit(frac_modulus_22bit),
        .dither_enable(dither_enable), .fastlock_enable(fastlock_enable));

    rmd_host_model u_rmd_host_model (
        .core_clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));

    // Count load pulses and capture the fields shown with each one
    always @(posedge core_clk) begin
        if (word_loaded === 1'b1) begin
            loads <= loads + 1;
            lat_n <= rf_integer_divide;
            lat_f <= rf_fraction_numerator;
        end
    end

    // Expected effective ratio; upper B bit unused with the low prescaler
    function automatic int exp_ratio(input logic [10:0] n, input logic p);
        return (p ? BASE_HIGH : BASE_LOW) * int'(n[10:4])
            + B_WEIGHT * int'(p ? n[3:2] : {1'b0, n[2]}) + int'(n[1:0]);
    endfunction

    // Expected range flag for the fixed modulator order
    function automatic logic exp_fault(input int r, input logic p);
        if (p) return 1'b0;
        return r < int'(N_MIN_LOW) || r > int'(N_MAX_LOW)
            || (r <= int'(N_ORD2_MAX) && ORDER_RST != ORDER_2)
            || (r <= int'(N_ORD3_MAX) && ORDER_RST != ORDER_2 && ORDER_RST != ORDER_3);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Compare every output with the expected state
    task automatic check_state(input string what);
        int r;
        r = exp_ratio(exp_n, rf_prescaler_select);
        check(32'(loads), 32'(exp_loads), "load pulses");
        check(32'({lat_n, lat_f}), 32'({exp_n, exp_fn}), "fields at pulse");
        check(32'(rf_integer_divide), 32'(exp_n), "integer");
        check(32'(rf_fraction_numerator), 32'(exp_fn), "fraction");
        check(32'({rf_coarse_count, rf_b_count, rf_a_count}), 32'(exp_n), "counts");
        check(32'(rf_divide_ratio), 32'(r[11:0]), "ratio");
        check(32'(range_fault), 32'(exp_fault(r, rf_prescaler_select)),
              "range");
        check(32'({modulator_order, frac_modulus_22bit, dither_enable, fastlock_enable}),
              32'({ORDER_RST, FRAC22_RST, DITHER_RST, FASTLK_RST}), "modes");
        $display("test %s done", what);
    endtask

    // Send a word and update the expected state when it should be taken
    task automatic xfer(input logic [31:0] bits, input int nbits, input logic take,
                        input string what);
        u_rmd_host_model.send_bits(bits, nbits);
        if (take) begin
            exp_n = bits[23:13];
            exp_fn = bits[12:1];
            exp_loads++;
        end
        check_state(what);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        rf_prescaler_select = 1'b0;
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        check_state("reset");
        for (int i = 0; i < 7; i++)
            xfer({8'h00, n_tab[i], f_tab[i], SEL_MAIN}, 24, 1'b1, "low table");
        xfer({8'h00, 11'h155, 12'h0f0, ~SEL_MAIN}, 24, 1'b0, "other select");
        xfer({9'h000, 11'h2aa, 12'h0f0}, 23, 1'b0, "short word");
        xfer({6'h00, 2'h3, 11'h155, 12'h3c3, SEL_MAIN}, 26, 1'b1, "long word");
        rf_prescaler_select = 1'b1;
        repeat (3) @(negedge core_clk);
        check_state("high select");
        xfer({8'h00, 11'h7ff, 12'h0ff, SEL_MAIN}, 24, 1'b1, "high top");
        rf_prescaler_select = 1'b0;
        repeat (3) @(negedge core_clk);
        check_state("low again");
        report_and_stop();
    end

    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
